// file: imd_pkg.sv
// Package of constants for the internal data memory decoder
package imd_pkg;
  // Lower segment and register banks
  localparam logic [7:0]  LOWER_LAST     = 8'h7f;
  localparam logic [7:0]  UPPER_FIRST    = 8'h80;
  localparam logic [7:0]  BANK_BYTES     = 8'h08;
  localparam logic [7:0]  BIT_AREA_BASE  = 8'h20;
  localparam logic [7:0]  BIT_AREA_LAST  = 8'h2f;
  // Expanded RAM
  localparam int          XADDR_W        = 16;
  localparam int          EXPANDED_INTERNAL_RAM_AW        = 11;
  localparam logic [15:0] EXPANDED_INTERNAL_RAM_FULL_SIZE = 16'h0800;
  localparam logic [15:0] EXPANDED_INTERNAL_RAM_MIN_SIZE  = 16'h0100;
  localparam logic [2:0]  SIZE_FIELD_RST = 3'h3;
  localparam logic        ROUTE_BIT_RST  = 1'b0;
  // Kinds of access presented by the core
  typedef enum logic [3:0] {
    IMD_DIRECT   = 4'h1,
    IMD_INDIRECT = 4'h2,
    IMD_REGISTER = 4'h4,
    IMD_BIT      = 4'h8
  } imd_mode_e;
endpackage

// file: imd_expanded_internal_ram.sv
// Expanded internal RAM storage, registered read data
module imd_expanded_internal_ram (
  // Clock
  input  wire logic                            i_clk,
  // Access
  input  wire logic                            i_en,
  input  wire logic                            i_we,
  input  wire logic [imd_pkg::EXPANDED_INTERNAL_RAM_AW-1:0]     i_addr,
  input  wire logic [7:0]                      i_wdata,
  // Read data
  output logic      [7:0]                      o_rdata
);
  logic [7:0] mem [0:(1<<imd_pkg::EXPANDED_INTERNAL_RAM_AW)-1];

  // No reset: contents are undefined after power-up
  always_ff @(posedge i_clk) begin
    if (i_en && i_we) begin
      mem[i_addr] <= i_wdata;
    end
    if (i_en) begin
      o_rdata <= mem[i_addr];
    end
  end
endmodule

// file: imd_decode.sv
// Internal data memory decoder with expanded RAM routing
// Summary of operation
// - Lower RAM answers 00h to 7Fh by both direct and indirect forms.
// - The first 32 bytes form 4 banks of 8 working registers.
// - The two bank select bits place the bank at 00h, 08h, 10h or 18h.
// - The 16 bytes above the banks give bits 00h to 7Fh to bit operations.
// - Upper RAM at 80h to FFh is reached by indirect access only.
// - Direct access to 80h to FFh goes to the function register space.
// - Expanded RAM of 2048 bytes answers external moves at 0000h to 07FFh.
// - Route bit clear sends external moves there, set sends them off chip.
// - A three-bit size field sets the usable expanded RAM size.
// - RAM is never cleared; software must initialise it before use.
// - Function registers at addresses ending 0 or 8 are bit-addressable.
module imd_decode (
  // Clock and reset
  input  wire logic                        i_clk,
  input  wire logic                        i_srst,
  // Internal access from the core
  input  wire logic                        i_req,
  input  wire logic [3:0]                  i_mode,
  input  wire logic [7:0]                  i_addr,
  input  wire logic                        i_bank_select_high,
  input  wire logic                        i_bank_select_low,
  // Auxiliary control register fields
  input  wire logic                        i_aux_we,
  input  wire logic                        i_external_ram_route_bit,
  input  wire logic [2:0]                  i_expanded_ram_size_field,
  // External move access
  input  wire logic                        i_xreq,
  input  wire logic                        i_xwe,
  input  wire logic [imd_pkg::XADDR_W-1:0] i_xaddr,
  input  wire logic [7:0]                  i_xwdata,
  // Internal decode results
  output logic                             o_lower_sel,
  output logic                             o_upper_sel,
  output logic                             o_sfr_sel,
  output logic      [7:0]                  o_ram_addr,
  output logic      [2:0]                  o_bit_pos,
  output logic                             o_bit_valid,
  // External move results
  output logic                             o_expanded_internal_ram_sel,
  output logic                             o_xbus_sel,
  output logic      [7:0]                  o_expanded_internal_ram_rdata,
  output logic                             o_route_bit,
  output logic      [2:0]                  o_size_field
);
  logic       route;
  logic       next_route;
  logic [2:0] size_f;
  logic [2:0] next_size_f;
  logic       d_lower, d_upper, d_sfr, d_bitv;
  logic [7:0] d_addr;
  logic [2:0] d_bitpos;
  logic [15:0] lim;
  logic       in_expanded_internal_ram;
  logic       next_expanded_internal_ram_sel;
  logic       next_xbus_sel;

  // Usable expanded RAM size in bytes for a size code
  function automatic logic [15:0] size_bytes(input logic [2:0] code);
    logic [15:0] b;
    b = imd_pkg::EXPANDED_INTERNAL_RAM_MIN_SIZE << code;
    if (b > imd_pkg::EXPANDED_INTERNAL_RAM_FULL_SIZE) begin
      b = imd_pkg::EXPANDED_INTERNAL_RAM_FULL_SIZE;
    end
    return b;
  endfunction

  // Auxiliary fields next value
  always_comb begin
    next_route  = route;
    next_size_f = size_f;
    if (i_aux_we) begin
      next_route  = i_external_ram_route_bit;
      next_size_f = i_expanded_ram_size_field;
    end
  end

  // Defaults select the full on-chip expanded RAM
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      route  <= imd_pkg::ROUTE_BIT_RST;
      size_f <= imd_pkg::SIZE_FIELD_RST;
    end else begin
      route  <= next_route;
      size_f <= next_size_f;
    end
  end

  // Internal space decode
  always_comb begin
    d_lower  = 1'b0;
    d_upper  = 1'b0;
    d_sfr    = 1'b0;
    d_bitv   = 1'b0;
    d_addr   = i_addr;
    d_bitpos = 3'h0;
    if (i_req) begin
      case (i_mode)
        imd_pkg::IMD_REGISTER: begin
          d_lower = 1'b1;
          d_addr  = {3'h0, i_bank_select_high, i_bank_select_low, 3'h0} |
                    {5'h00, i_addr[2:0]};
        end
        imd_pkg::IMD_DIRECT: begin
          if (i_addr <= imd_pkg::LOWER_LAST) begin
            d_lower = 1'b1;
          end else begin
            d_sfr = 1'b1;
          end
        end
        imd_pkg::IMD_INDIRECT: begin
          if (i_addr <= imd_pkg::LOWER_LAST) begin
            d_lower = 1'b1;
          end else begin
            d_upper = 1'b1;
          end
        end
        imd_pkg::IMD_BIT: begin
          d_bitpos = i_addr[2:0];
          d_bitv   = 1'b1;
          if (!i_addr[7]) begin
            d_lower = 1'b1;
            d_addr  = imd_pkg::BIT_AREA_BASE + {4'h0, i_addr[6:3]};
          end else begin
            d_sfr  = 1'b1;
            d_addr = {i_addr[7:3], 3'h0};
          end
        end
        default: begin
          d_addr = i_addr;
        end
      endcase
    end
  end

  // Registered decode results
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_lower_sel <= 1'b0;
      o_upper_sel <= 1'b0;
      o_sfr_sel   <= 1'b0;
      o_ram_addr  <= 8'h00;
      o_bit_pos   <= 3'h0;
      o_bit_valid <= 1'b0;
    end else begin
      o_lower_sel <= d_lower;
      o_upper_sel <= d_upper;
      o_sfr_sel   <= d_sfr;
      o_ram_addr  <= d_addr;
      o_bit_pos   <= d_bitpos;
      o_bit_valid <= d_bitv;
    end
  end

  // Expanded RAM window limited by size field and route bit
  always_comb begin
    lim           = size_bytes(size_f);
    in_expanded_internal_ram       = i_xaddr < lim;
    next_expanded_internal_ram_sel = i_xreq && in_expanded_internal_ram && !route;
    next_xbus_sel = i_xreq && !next_expanded_internal_ram_sel;
  end

  // Registered routing selects
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_expanded_internal_ram_sel <= 1'b0;
      o_xbus_sel <= 1'b0;
    end else begin
      o_expanded_internal_ram_sel <= next_expanded_internal_ram_sel;
      o_xbus_sel <= next_xbus_sel;
    end
  end

  assign o_route_bit  = route;
  assign o_size_field = size_f;

  imd_expanded_internal_ram u_expanded_internal_ram (
    .i_clk   (i_clk),
    .i_en    (next_expanded_internal_ram_sel),
    .i_we    (i_xwe),
    .i_addr  (i_xaddr[imd_pkg::EXPANDED_INTERNAL_RAM_AW-1:0]),
    .i_wdata (i_xwdata),
    .o_rdata (o_expanded_internal_ram_rdata)
  );

  // Checks
  property p_direct_high_sfr;
    @(posedge i_clk) disable iff (i_srst)
      (i_req && i_mode == imd_pkg::IMD_DIRECT && i_addr[7])
      |=> (o_sfr_sel && !o_upper_sel);
  endproperty
  a_direct_high_sfr: assert property (p_direct_high_sfr)
    else $error("direct high access missed sfr");

  property p_indirect_high_upper;
    @(posedge i_clk) disable iff (i_srst)
      (i_req && i_mode == imd_pkg::IMD_INDIRECT && i_addr[7])
      |=> (o_upper_sel && !o_sfr_sel);
  endproperty
  a_indirect_high_upper: assert property (p_indirect_high_upper)
    else $error("indirect high access missed upper ram");

  property p_lower_both;
    @(posedge i_clk) disable iff (i_srst)
      (i_req && !i_addr[7] && (i_mode == imd_pkg::IMD_DIRECT ||
       i_mode == imd_pkg::IMD_INDIRECT))
      |=> (o_lower_sel && o_ram_addr[7] == 1'b0);
  endproperty
  a_lower_both: assert property (p_lower_both)
    else $error("lower ram not selected");

  property p_bank_base;
    @(posedge i_clk) disable iff (i_srst)
      (i_req && i_mode == imd_pkg::IMD_REGISTER)
      |=> (o_ram_addr == {3'h0, $past(i_bank_select_high),
           $past(i_bank_select_low), $past(i_addr[2:0])});
  endproperty
  a_bank_base: assert property (p_bank_base)
    else $error("bank address wrong");

  property p_bit_area;
    @(posedge i_clk) disable iff (i_srst)
      (i_req && i_mode == imd_pkg::IMD_BIT && !i_addr[7])
      |=> (o_ram_addr >= imd_pkg::BIT_AREA_BASE &&
           o_ram_addr <= imd_pkg::BIT_AREA_LAST && o_lower_sel);
  endproperty
  a_bit_area: assert property (p_bit_area)
    else $error("bit area address out of range");

  property p_sfr_bit;
    @(posedge i_clk) disable iff (i_srst)
      (i_req && i_mode == imd_pkg::IMD_BIT && i_addr[7])
      |=> (o_sfr_sel && o_ram_addr[2:0] == 3'h0);
  endproperty
  a_sfr_bit: assert property (p_sfr_bit)
    else $error("sfr bit address not aligned");

  property p_route_off;
    @(posedge i_clk) disable iff (i_srst)
      (i_xreq && route) |=> (o_xbus_sel && !o_expanded_internal_ram_sel);
  endproperty
  a_route_off: assert property (p_route_off)
    else $error("route bit ignored");

  property p_beyond_size;
    @(posedge i_clk) disable iff (i_srst)
      (i_xreq && i_xaddr >= imd_pkg::EXPANDED_INTERNAL_RAM_FULL_SIZE) |=> o_xbus_sel;
  endproperty
  a_beyond_size: assert property (p_beyond_size)
    else $error("address beyond size stayed on chip");

  property p_expanded_internal_ram_default;
    @(posedge i_clk) disable iff (i_srst)
      (i_xreq && !route && size_f == imd_pkg::SIZE_FIELD_RST &&
       i_xaddr < imd_pkg::EXPANDED_INTERNAL_RAM_FULL_SIZE) |=> (o_expanded_internal_ram_sel && !o_xbus_sel);
  endproperty
  a_expanded_internal_ram_default: assert property (p_expanded_internal_ram_default)
    else $error("expanded ram not selected");
endmodule

// file: imd_decode_bench.sv
// Self-checking bench for the internal data memory decoder
module imd_decode_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        i_clk = 0, i_srst = 1, i_req = 0, i_aux_we = 0;
  logic [3:0]  i_mode = 4'h1;
  logic [7:0]  i_addr = 8'h00, i_xwdata = 8'h00;
  logic        i_bank_select_high = 0, i_bank_select_low = 0;
  logic        i_external_ram_route_bit = 0, i_xreq = 0, i_xwe = 0;
  logic [2:0]  i_expanded_ram_size_field = 3'h3;
  logic [15:0] i_xaddr = 16'h0000;
  logic        o_lower_sel, o_upper_sel, o_sfr_sel, o_bit_valid;
  logic        o_expanded_internal_ram_sel, o_xbus_sel, o_route_bit;
  logic [7:0]  o_ram_addr, o_expanded_internal_ram_rdata;
  logic [2:0]  o_bit_pos, o_size_field;
  int          mismatches = 0, samples_checked = 0;
  logic [7:0]  mem [2048];
  bit          known [2048];
  logic        route = 0;
  logic [2:0]  size = 3'h3;
  logic [7:0]  seg_edges [6] = '{8'h00, 8'h1f, 8'h7f, 8'h80, 8'h88, 8'hff};

  imd_decode dut (
    .i_clk                     (i_clk),
    .i_srst                    (i_srst),
    .i_req                     (i_req),
    .i_mode                    (i_mode),
    .i_addr                    (i_addr),
    .i_bank_select_high        (i_bank_select_high),
    .i_bank_select_low         (i_bank_select_low),
    .i_aux_we                  (i_aux_we),
    .i_external_ram_route_bit  (i_external_ram_route_bit),
    .i_expanded_ram_size_field (i_expanded_ram_size_field),
    .i_xreq                    (i_xreq),
    .i_xwe                     (i_xwe),
    .i_xaddr                   (i_xaddr),
    .i_xwdata                  (i_xwdata),
    .o_lower_sel               (o_lower_sel),
    .o_upper_sel               (o_upper_sel),
    .o_sfr_sel                 (o_sfr_sel),
    .o_ram_addr                (o_ram_addr),
    .o_bit_pos                 (o_bit_pos),
    .o_bit_valid               (o_bit_valid),
    .o_expanded_internal_ram_sel                (o_expanded_internal_ram_sel),
    .o_xbus_sel                (o_xbus_sel),
    .o_expanded_internal_ram_rdata              (o_expanded_internal_ram_rdata),
    .o_route_bit               (o_route_bit),
    .o_size_field              (o_size_field)
  );

  // Clock at 100 MHz
  initial begin
    forever #5 i_clk = ~i_clk;
  end

  task automatic chk(string n, logic [15:0] e, logic [15:0] s);
    samples_checked++;
    if (s !== e) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask

  // Usable expanded size, capped at the full 2048 bytes
  function automatic int lim(logic [2:0] n);
    return ((256 << n) > 2048) ? 2048 : (256 << n);
  endfunction

  // Expected {lower, upper, sfr, byte address}
  function automatic logic [10:0] exp_int(logic [3:0] m, logic [7:0] a,
                                          logic [1:0] b);
    case (m)
      4'h1: return a[7] ? {3'b001, a} : {3'b100, a};
      4'h2: return a[7] ? {3'b010, a} : {3'b100, a};
      4'h4: return {3'b100, 3'h0, b, a[2:0]};
      4'h8: return a[7] ? {3'b001, a & 8'hf8} : {3'b100, 8'h20 + a[6:3]};
      default: return 11'h000;
    endcase
  endfunction

  task automatic int_op(logic r, logic [3:0] m, logic [7:0] a,
                        logic [1:0] b);
    logic [10:0] e;
    i_req = r; i_mode = m; i_addr = a;
    {i_bank_select_high, i_bank_select_low} = b;
    e = r ? exp_int(m, a, b) : 11'h000;
    @(negedge i_clk);
    chk("selects", e[10:8], {o_lower_sel, o_upper_sel, o_sfr_sel});
    if (r) chk("ram_addr", e[7:0], o_ram_addr);
    if (r && m == 4'h8) chk("bit_pos", a[2:0], o_bit_pos);
    if (r) chk("bit_valid", m == 4'h8, o_bit_valid);
  endtask

  // Request line drops here, so back-to-back moves keep it held high
  task automatic aux_set(logic rb, logic [2:0] n);
    i_xreq = 0;
    i_aux_we = 1; i_external_ram_route_bit = rb;
    i_expanded_ram_size_field = n;
    @(negedge i_clk);
    i_aux_we = 0; route = rb; size = n;
    chk("route", rb, o_route_bit);
    chk("size", n, o_size_field);
  endtask

  task automatic x_op(logic w, logic [15:0] a, logic [7:0] d);
    logic on;
    on = !route && (a < lim(size));
    i_xreq = 1; i_xwe = w; i_xaddr = a; i_xwdata = d;
    @(negedge i_clk);
    chk("expanded_internal_ram_sel", on, o_expanded_internal_ram_sel);
    chk("xbus_sel", !on, o_xbus_sel);
    if (on && !w && known[a[10:0]])
      chk("expanded_internal_ram_rdata", mem[a[10:0]], o_expanded_internal_ram_rdata);
    if (on && w) begin
      mem[a[10:0]] = d; known[a[10:0]] = 1;
    end
  endtask

  task automatic summarize;
    if (mismatches == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Watchdog, well beyond the roughly 700 cycles the tests need
  initial begin
    #200000;
    mismatches++;
    summarize();
  end

  // Main sequence
  initial begin
    logic [15:0] a;
    void'($urandom(78555));
    repeat (6) @(negedge i_clk);
    i_srst = 0;
    chk("route_rst", 1'b0, o_route_bit);
    chk("size_rst", 3'h3, o_size_field);
    // Segment edges in every mode, back to back
    for (int m = 0; m < 4; m++) begin
      foreach (seg_edges[k])
        int_op(1, 4'h1 << m, seg_edges[k], 2'(m));
    end
    int_op(0, 4'h2, 8'h90, 2'h1);
    int_op(1, 4'h3, 8'h00, 2'h0);
    repeat (300) int_op(1, 4'h1 << ($urandom % 4), 8'($urandom),
                        2'($urandom));
    // Default route and size: full range on chip
    x_op(1, 16'h07ff, 8'h5a);
    x_op(0, 16'h07ff, 8'h00);
    x_op(0, 16'h0800, 8'h00);
    for (int n = 0; n < 8; n++) begin
      aux_set(0, 3'(n));
      x_op(1, 16'(lim(3'(n)) - 1), 8'(n + 8'h30));
      x_op(0, 16'(lim(3'(n)) - 1), 8'h00);
      x_op(1, 16'(lim(3'(n))), 8'h11);
      repeat (20) begin
        a = 16'($urandom % 4096);
        x_op(1'($urandom), a, 8'($urandom));
        x_op(0, a, 8'h00);
      end
    end
    aux_set(1, 3'h3);
    x_op(0, 16'h0000, 8'h00);
    x_op(1, 16'h0100, 8'hff);
    // Mid-run reset with the route bit set must restore defaults
    i_srst = 1; i_xreq = 0;
    @(negedge i_clk);
    i_srst = 0; route = 0; size = 3'h3;
    chk("route_rst", 1'b0, o_route_bit);
    chk("size_rst", 3'h3, o_size_field);
    chk("sel_rst", 3'h0, {o_lower_sel, o_upper_sel, o_sfr_sel});
    aux_set(0, 3'h3);
    x_op(0, 16'h07ff, 8'h00);
    summarize();
  end
endmodule
